/* File: hdl/pmcs_pkg.sv */
// Purpose: Shared constants and types of the peripheral and midrange select block.
// Assumes: Registers are 16 bits wide and sit in the low half of a 32-bit word.
// Notes:   Byte offsets are word aligned.
package pmcs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] PMCS_OFF_PBASE  = 8'ha4;
    localparam logic [7:0] PMCS_OFF_AUX    = 8'ha8;
    localparam logic [7:0] PMCS_OFF_MBASE  = 8'hac;
    localparam logic [7:0] PMCS_OFF_SYSCFG = 8'hb0;
    localparam logic [7:0] PMCS_OFF_STATUS = 8'hb4;

    ////////////////////////////////////////////////////////////////////////////
    localparam int PMCS_MSZ_LSB    = 8;
    localparam int PMCS_MSZ_W      = 7;
    localparam int PMCS_PFUNC_BIT  = 7;
    localparam int PMCS_SPACE_BIT  = 6;
    localparam int PMCS_WEXT_BIT   = 3;
    localparam int PMCS_RDY_BIT    = 2;
    localparam int PMCS_WAIT_LSB   = 0;
    localparam int PMCS_PBASE_LSB  = 7;
    localparam int PMCS_PBASE_W    = 9;
    localparam int PMCS_MBASE_LSB  = 9;
    localparam int PMCS_MBASE_W    = 7;
    localparam int PMCS_WHOLE_BIT  = 0;
    localparam int PMCS_ADDR_W     = 20;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [15:0] PMCS_RST_REG  = 16'h0000;
    localparam logic [3:0]  PMCS_WS_NONE  = 4'h0;
    localparam int          PMCS_SYNC_N   = 2;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [19:0] addr;
        logic        mem;
    } pmcs_cyc_t;

    typedef struct packed {
        logic [3:0] ws;
        logic       rdy_ign;
    } pmcs_wait_t;

    typedef enum logic [0:0] {
        PH_IDLE,
        PH_ACTIVE
    } pmcs_phase_t;

endpackage

/* File: hdl/pmcs_pdec.sv */
// Purpose: Peripheral select address compare, seven 256-byte slots.
// Assumes: The base covers address bits 19 to 11 of the cycle.
// Notes:   Slot four keeps its output bit low and never hits.
module pmcs_pdec #(
    parameter int ADDR_W = 20
) (
    input  wire logic                    en_i,
    input  wire logic                    space_i,
    input  wire logic [8:0]              base_i,
    input  wire pmcs_pkg::pmcs_cyc_t     cyc_i,
    output logic      [6:0]              hit_o
);

    ////////////////////////////////////////////////////////////////////////////
    if (ADDR_W != pmcs_pkg::PMCS_ADDR_W) begin : g_chk
        $error("pmcs_pdec serves a 20-bit address only.");
    end

    wire logic       blk_hit = en_i && (cyc_i.mem == space_i)
                             && (cyc_i.addr[19:11] == base_i);
    wire logic [2:0] slot    = cyc_i.addr[10:8];

    ////////////////////////////////////////////////////////////////////////////
    // Each slot spans 256 bytes; slot index four is left dark.
    for (genvar i = 0; i < 7; i++) begin : g_slot
        assign hit_o[i] = (i != 4) && blk_hit && (slot == 3'(i));
    end

endmodule

/* File: hdl/pmcs_mdec.sv */
// Purpose: Midrange select compare over a one-hot block size.
// Assumes: At most one size bit is set; other patterns give no defined result.
// Notes:   A size field of zero matches nothing.
module pmcs_mdec #(
    parameter int ADDR_W = 20
) (
    input  wire logic                    en_i,
    input  wire logic                    whole_i,
    input  wire logic [6:0]              size_i,
    input  wire logic [6:0]              base_i,
    input  wire pmcs_pkg::pmcs_cyc_t     cyc_i,
    output logic      [3:0]              hit_o
);

    ////////////////////////////////////////////////////////////////////////////
    if (ADDR_W != pmcs_pkg::PMCS_ADDR_W) begin : g_chk
        $error("pmcs_mdec serves a 20-bit address only.");
    end

    // Bits below the size bit lie inside the block and are not compared.
    wire logic [6:0] mask   = ~(size_i - 7'h01);
    wire logic       in_blk = en_i && cyc_i.mem && (size_i != 7'h00)
                            && ((cyc_i.addr[19:13] & mask) == (base_i & mask));
    logic      [1:0] quarter;

    always_comb begin
        quarter = 2'h0;
        for (int k = 0; k < 7; k++) begin
            if (size_i[k]) begin
                quarter = cyc_i.addr[11+k +: 2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    for (genvar q = 0; q < 4; q++) begin : g_q
        if (q == 0) begin : g_zero
            assign hit_o[q] = in_blk && (whole_i || quarter == 2'h0);
        end else begin : g_rest
            assign hit_o[q] = in_blk && (quarter == 2'(q));
        end
    end

endmodule

/* File: hdl/pmcs_top.sv */
// Purpose: Peripheral and midrange chip select decoder with its registers.
// Assumes: Bus cycle inputs come from logic on clk_i; ext_ready_i is a pin.
// Notes:   Selects change only on the address phase strobe or the cycle end of a bus cycle.
//
// Operation
// - Midrange total size is a one-hot field, 8K to 512K; each select covers a quarter.
// - With the whole-block option set, midrange select zero spans the whole block.
// - Pin-function bit 7: 1 gives selects five and six, 0 gives latched A1 and A2.
// - In address mode any auxiliary register access enables the outputs.
// - Space bit 6: peripheral selects decode memory cycles at 1, I/O at 0.
// - Auxiliary ready bit: 0 needs external ready for selects five and six.
// - Auxiliary wait field adds zero to three waits for selects five and six.
// - Peripheral selects stay off until base and auxiliary registers are written.
// - Peripheral base bits 15 to 7 give address bits 19 to 11.
// - Peripheral selects cover 256 bytes each; slot four is reserved.
// - Peripheral selects assert with the multiplexed address phase.
// - Selects zero to three wait 0 to 3, or 5, 7, 9, 15 when extended.
// - Peripheral base ready bit: 0 needs external ready for selects zero to three.
// - Midrange base gives address bits 19 to 13, aligned to the block size.
// - Midrange selects stay off until midrange base and auxiliary are accessed.
//
// Added by the designer: register access over Wishbone.
module pmcs_top (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic [7:0]              adr_i,
    input  wire logic [31:0]             dat_i,
    output logic      [31:0]             dat_o,
    input  wire logic [3:0]              sel_i,
    input  wire logic                    we_i,
    input  wire logic                    cyc_i,
    input  wire logic                    stb_i,
    output logic                         ack_o,
    input  wire logic [19:0]             bus_addr_i,
    input  wire logic                    bus_mem_i,
    input  wire logic                    bus_addr_phase_i,
    input  wire logic                    bus_cycle_end_i,
    input  wire logic                    ext_ready_i,
    output logic      [3:0]              midrange_sel_n_o,
    output logic      [3:0]              lower_periph_sel_n_o,
    output logic      [1:0]              upper_periph_sel_o,
    output logic      [3:0]              wait_states_o,
    output logic                         ready_ignore_o,
    output logic                         bus_ready_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [15:0] pbase_r;
    logic [15:0] aux_r;
    logic [15:0] mbase_r;
    logic        whole_r;
    logic        pbase_wr_r;
    logic        aux_wr_r;
    logic        aux_acc_r;
    logic        mbase_acc_r;
    logic        ack_r;
    logic [31:0] rdat_r;

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle state.
    pmcs_pkg::pmcs_phase_t phase_r;
    pmcs_pkg::pmcs_phase_t phase_nxt;
    pmcs_pkg::pmcs_wait_t  pol_r;
    pmcs_pkg::pmcs_wait_t  pol_nxt;
    logic [3:0]            mcs_r;
    logic [3:0]            pcs_lo_r;
    logic [1:0]            pcs_hi_r;
    logic [1:0]            a21_r;
    logic [3:0]            cnt_r;
    logic [3:0]            cnt_nxt;
    logic [1:0]            rdy_sync_r;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone decode.
    wire logic req       = cyc_i && stb_i && !ack_r;
    wire logic hit_pbase = adr_i[7:2] == pmcs_pkg::PMCS_OFF_PBASE[7:2];
    wire logic hit_aux   = adr_i[7:2] == pmcs_pkg::PMCS_OFF_AUX[7:2];
    wire logic hit_mbase = adr_i[7:2] == pmcs_pkg::PMCS_OFF_MBASE[7:2];
    wire logic hit_sys   = adr_i[7:2] == pmcs_pkg::PMCS_OFF_SYSCFG[7:2];
    wire logic hit_stat  = adr_i[7:2] == pmcs_pkg::PMCS_OFF_STATUS[7:2];
    wire logic wr        = req && we_i;
    wire logic wr_pbase  = wr && hit_pbase;
    wire logic wr_aux    = wr && hit_aux;
    wire logic wr_mbase  = wr && hit_mbase;
    wire logic wr_sys    = wr && hit_sys;
    wire logic acc_aux   = req && hit_aux;
    wire logic acc_mbase = req && hit_mbase;

    // Byte lanes zero and one carry the 16-bit register.
    wire logic [15:0] lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [15:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    wire logic [15:0] status_val = {10'h000, (phase_r == pmcs_pkg::PH_ACTIVE),
                                    bus_ready_o, mbase_acc_r, aux_acc_r,
                                    aux_wr_r, pbase_wr_r};

    // Unmapped words acknowledge and read as zero.
    wire logic [15:0] rd_mux = hit_pbase ? pbase_r :
                               hit_aux   ? aux_r   :
                               hit_mbase ? mbase_r :
                               hit_sys   ? {15'h0000, whole_r} :
                               hit_stat  ? status_val : 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Register file. Contents after reset are defined as zero, but the
    // enables below keep every select dark until software writes them or, for midrange selects, accesses them.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pbase_r <= pmcs_pkg::PMCS_RST_REG;
            aux_r   <= pmcs_pkg::PMCS_RST_REG;
            mbase_r <= pmcs_pkg::PMCS_RST_REG;
            whole_r <= 1'b0;
        end else begin
            if (wr_pbase) begin
                pbase_r <= merge(pbase_r, dat_i[15:0], lane_mask);
            end
            if (wr_aux) begin
                aux_r <= merge(aux_r, dat_i[15:0], lane_mask);
            end
            if (wr_mbase) begin
                mbase_r <= merge(mbase_r, dat_i[15:0], lane_mask);
            end
            if (wr_sys && sel_i[0]) begin
                whole_r <= dat_i[pmcs_pkg::PMCS_WHOLE_BIT];
            end
        end
    end

    // Activation flags are sticky until reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pbase_wr_r  <= 1'b0;
            aux_wr_r    <= 1'b0;
            aux_acc_r   <= 1'b0;
            mbase_acc_r <= 1'b0;
        end else begin
            pbase_wr_r  <= pbase_wr_r || wr_pbase;
            aux_wr_r    <= aux_wr_r || wr_aux;
            aux_acc_r   <= aux_acc_r || acc_aux;
            mbase_acc_r <= mbase_acc_r || acc_mbase;
        end
    end

    // One wait state on every access keeps the read path registered.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r  <= req;
            rdat_r <= req ? {16'h0000, rd_mux} : rdat_r;
        end
    end

    assign ack_o = ack_r;
    assign dat_o = rdat_r;

    ////////////////////////////////////////////////////////////////////////////
    // Field views.
    wire logic [6:0] msize     = aux_r[pmcs_pkg::PMCS_MSZ_LSB +: pmcs_pkg::PMCS_MSZ_W];
    wire logic       pin_sel   = aux_r[pmcs_pkg::PMCS_PFUNC_BIT];
    wire logic       space_mem = aux_r[pmcs_pkg::PMCS_SPACE_BIT];
    wire logic [8:0] pbase     = pbase_r[pmcs_pkg::PMCS_PBASE_LSB +: pmcs_pkg::PMCS_PBASE_W];
    wire logic [6:0] mbase     = mbase_r[pmcs_pkg::PMCS_MBASE_LSB +: pmcs_pkg::PMCS_MBASE_W];

    wire logic pcs_en   = pbase_wr_r && aux_wr_r;
    wire logic addr_en  = aux_acc_r && !pin_sel;
    wire logic mcs_en   = mbase_acc_r && aux_acc_r;

    wire pmcs_pkg::pmcs_cyc_t cyc = '{addr: bus_addr_i, mem: bus_mem_i};

    logic [6:0] p_hit;
    logic [3:0] m_hit;

    pmcs_pdec #(
        .ADDR_W (pmcs_pkg::PMCS_ADDR_W)
    ) u_pdec (
        .en_i    (pcs_en),
        .space_i (space_mem),
        .base_i  (pbase),
        .cyc_i   (cyc),
        .hit_o   (p_hit)
    );

    pmcs_mdec #(
        .ADDR_W (pmcs_pkg::PMCS_ADDR_W)
    ) u_mdec (
        .en_i    (mcs_en),
        .whole_i (whole_r),
        .size_i  (msize),
        .base_i  (mbase),
        .cyc_i   (cyc),
        .hit_o   (m_hit)
    );

    // Upper slots drive selects only when the pins are in select mode.
    wire logic [1:0] up_hit = p_hit[6:5] & {2{pin_sel}};

    ////////////////////////////////////////////////////////////////////////////
    // Wait policy of the decoded cycle; peripheral ranges take precedence.
    wire logic [1:0] pws      = pbase_r[pmcs_pkg::PMCS_WAIT_LSB +: 2];
    wire logic [1:0] aws      = aux_r[pmcs_pkg::PMCS_WAIT_LSB +: 2];
    wire logic [1:0] mws      = mbase_r[pmcs_pkg::PMCS_WAIT_LSB +: 2];
    wire logic       pext     = pbase_r[pmcs_pkg::PMCS_WEXT_BIT];

    // Extended encoding jumps to 5, 7, 9 and 15 wait states.
    wire logic [3:0] pws_ext  = (pws == 2'h3) ? 4'hf : {1'b0, pws, 1'b1} + 4'h4;
    wire logic [3:0] pws_full = pext ? pws_ext : {2'h0, pws};

    always_comb begin
        pol_nxt = '{ws: pmcs_pkg::PMCS_WS_NONE, rdy_ign: 1'b0};
        if (|p_hit[3:0]) begin
            pol_nxt.ws      = pws_full;
            pol_nxt.rdy_ign = pbase_r[pmcs_pkg::PMCS_RDY_BIT];
        end else if (|up_hit) begin
            pol_nxt.ws      = {2'h0, aws};
            pol_nxt.rdy_ign = aux_r[pmcs_pkg::PMCS_RDY_BIT];
        end else if (|m_hit) begin
            pol_nxt.ws      = {2'h0, mws};
            pol_nxt.rdy_ign = mbase_r[pmcs_pkg::PMCS_RDY_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencing.
    always_comb begin
        phase_nxt = phase_r;
        unique case (phase_r)
            pmcs_pkg::PH_IDLE: begin
                if (bus_addr_phase_i) begin
                    phase_nxt = pmcs_pkg::PH_ACTIVE;
                end
            end
            pmcs_pkg::PH_ACTIVE: begin
                if (bus_cycle_end_i) begin
                    phase_nxt = pmcs_pkg::PH_IDLE;
                end
            end
        endcase
    end

    always_comb begin
        cnt_nxt = cnt_r;
        if (bus_addr_phase_i) begin
            cnt_nxt = pol_nxt.ws;
        end else if (phase_r == pmcs_pkg::PH_ACTIVE && cnt_r != 4'h0) begin
            cnt_nxt = cnt_r - 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Selects are caught on the address phase strobe, so they follow the
    // multiplexed address timing and never glitch within a cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_r  <= pmcs_pkg::PH_IDLE;
            mcs_r    <= 4'h0;
            pcs_lo_r <= 4'h0;
            pcs_hi_r <= 2'h0;
            pol_r    <= '{ws: pmcs_pkg::PMCS_WS_NONE, rdy_ign: 1'b0};
            cnt_r    <= 4'h0;
        end else begin
            phase_r <= phase_nxt;
            cnt_r   <= cnt_nxt;
            if (bus_addr_phase_i) begin
                mcs_r    <= m_hit;
                pcs_lo_r <= p_hit[3:0];
                pcs_hi_r <= up_hit;
                pol_r    <= pol_nxt;
            end else if (bus_cycle_end_i) begin
                mcs_r    <= 4'h0;
                pcs_lo_r <= 4'h0;
                pcs_hi_r <= 2'h0;
            end
        end
    end

    // Address bits stay latched between cycles, like a transparent latch.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a21_r <= 2'h0;
        end else if (bus_addr_phase_i) begin
            a21_r <= bus_addr_i[2:1];
        end
    end

    // The ready pin is asynchronous and passes two flip-flops first.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdy_sync_r <= 2'h0;
        end else begin
            rdy_sync_r <= {rdy_sync_r[0], ext_ready_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    wire logic rdy_ok = pol_r.rdy_ign || rdy_sync_r[1];

    assign bus_ready_o    = (phase_r == pmcs_pkg::PH_ACTIVE)
                            && (cnt_r == 4'h0) && rdy_ok;
    assign wait_states_o  = pol_r.ws;
    assign ready_ignore_o = pol_r.rdy_ign;

    assign midrange_sel_n_o     = ~mcs_r;
    assign lower_periph_sel_n_o = ~pcs_lo_r;

    // Address mode shows A1 on output five and A2 on output six; with
    // neither mode enabled both outputs idle high.
    assign upper_periph_sel_o = addr_en ? a21_r : ~pcs_hi_r;

endmodule

/* File: dv/pmcs_assertions.sv */
// Purpose: Port level timing and value checks on the select block.
// Assumes: One clock; synchronous reset, active high.
// Notes:   An address phase never shares its cycle with a cycle end.
module pmcs_assertions (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        ack_o,
    input wire logic        bus_addr_phase_i,
    input wire logic        bus_cycle_end_i,
    input wire logic        ext_ready_i,
    input wire logic [3:0]  midrange_sel_n_o,
    input wire logic [3:0]  lower_periph_sel_n_o,
    input wire logic [3:0]  wait_states_o,
    input wire logic        ready_ignore_o,
    input wire logic        bus_ready_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////
    property p_ack_resp; (cyc_i && stb_i && !ack_o) |=> ack_o; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
    property p_sel_move;
        !$stable({midrange_sel_n_o, lower_periph_sel_n_o})
            |-> $past(bus_addr_phase_i) || $past(bus_cycle_end_i);
    endproperty
    a_sel_move: assert property (p_sel_move) else $error("select moved off phase");
    property p_end_off;
        bus_cycle_end_i |=> (&midrange_sel_n_o) && (&lower_periph_sel_n_o) && !bus_ready_o;
    endproperty
    a_end_off: assert property (p_end_off) else $error("select held past end");
    property p_ws_set; wait_states_o inside {0, 1, 2, 3, 5, 7, 9, 15}; endproperty
    a_ws_set: assert property (p_ws_set) else $error("illegal wait count");
    property p_one_slot; $onehot0(~lower_periph_sel_n_o); endproperty
    a_one_slot: assert property (p_one_slot) else $error("two slots selected");
    property p_ready_now;
        bus_addr_phase_i ##1 (ready_ignore_o && wait_states_o == 4'h0) |-> bus_ready_o;
    endproperty
    a_ready_now: assert property (p_ready_now) else $error("ready late");
    property p_wait3;
        bus_addr_phase_i ##1 (wait_states_o == 4'h3) |-> !bus_ready_o [*3];
    endproperty
    a_wait3: assert property (p_wait3) else $error("ready before waits");
    property p_rdy_sync; (bus_ready_o && !ready_ignore_o) |-> $past(ext_ready_i, 2); endproperty
    a_rdy_sync: assert property (p_rdy_sync) else $error("ready without pin");
    c_ready_now: cover property (bus_addr_phase_i ##1 (ready_ignore_o && wait_states_o == 4'h0));
    c_whole: cover property (!midrange_sel_n_o[0] && !midrange_sel_n_o[2]);
    c_slow: cover property (!ready_ignore_o ##1 bus_ready_o);
endmodule

bind pmcs_top pmcs_assertions i_pmcs_assertions (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .bus_addr_phase_i(bus_addr_phase_i),
    .bus_cycle_end_i(bus_cycle_end_i), .ext_ready_i(ext_ready_i),
    .midrange_sel_n_o(midrange_sel_n_o), .lower_periph_sel_n_o(lower_periph_sel_n_o),
    .wait_states_o(wait_states_o), .ready_ignore_o(ready_ignore_o), .bus_ready_o(bus_ready_o));

/* File: dv/pmcs_dev_model.sv */
// Purpose: Selected memory or peripheral device answering with ready.
// Assumes: Selects are active low and registered.
// Notes:   Delay after select is set per cycle by the bench.
module pmcs_dev_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] midrange_sel_n_i,
    input  wire logic [3:0] lower_periph_sel_n_i,
    input  wire logic [1:0] slow_i,
    output logic            ext_ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_r;
    logic       idle_r;
    wire        picked = ~&{midrange_sel_n_i, lower_periph_sel_n_i};
    always_ff @(posedge clk_i) begin
        if (rst_i || !picked) cnt_r <= 2'h0;
        else if (cnt_r != slow_i) cnt_r <= cnt_r + 2'h1;
        idle_r <= rst_i ? 1'b0 : ~idle_r;
    end
    // A released line must not keep its last level, so it flips every cycle.
    assign ext_ready_o = picked ? (cnt_r == slow_i) : idle_r;
endmodule

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench of the peripheral and midrange select block.
// Assumes: Design answers Wishbone in one cycle and decodes at the phase pulse.
// Notes:   One queue holds read data and select notes in issue order.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic [3:0]  sel_i = 4'h0, midrange_sel_n_o, lower_periph_sel_n_o, wait_states_o;
    logic [19:0] bus_addr_i = 20'h0, blk, mb;
    logic        bus_mem_i = 1'b1, bus_addr_phase_i = 1'b0, bus_cycle_end_i = 1'b0;
    logic        ack_o, ready_ignore_o, bus_ready_o, ext_ready_i, phase_d = 1'b0;
    logic [1:0]  upper_periph_sel_o, slow_r = 2'h0;
    logic [8:0]  pb;
    logic [3:0]  wtab [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hf};
    logic [31:0] exp_q [$];
    int          mismatches = 0, samples_checked = 0, cycles = 0;
    pmcs_top i_pmcs_top (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .ack_o(ack_o), .bus_addr_i(bus_addr_i), .bus_mem_i(bus_mem_i),
        .bus_addr_phase_i(bus_addr_phase_i), .bus_cycle_end_i(bus_cycle_end_i),
        .ext_ready_i(ext_ready_i), .midrange_sel_n_o(midrange_sel_n_o),
        .lower_periph_sel_n_o(lower_periph_sel_n_o), .upper_periph_sel_o(upper_periph_sel_o),
        .wait_states_o(wait_states_o), .ready_ignore_o(ready_ignore_o),
        .bus_ready_o(bus_ready_o));
    pmcs_dev_model i_pmcs_dev_model (.clk_i(clk_i), .rst_i(rst_i),
        .midrange_sel_n_i(midrange_sel_n_o), .lower_periph_sel_n_i(lower_periph_sel_n_o),
        .slow_i(slow_r), .ext_ready_o(ext_ready_i));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        phase_d <= bus_addr_phase_i;
        if (ack_o === 1'b1 && we_i === 1'b0) check("dat_o", dat_o, exp_q.pop_front());
        if (phase_d === 1'b1) check("selects", {17'h0, midrange_sel_n_o, lower_periph_sel_n_o,
            upper_periph_sel_o, wait_states_o, ready_ignore_o}, exp_q.pop_front());
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    // Hangs in the waits below are cut by the cycle ceiling above.
    task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d);
        if (!w) exp_q.push_back({16'h0, d});
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {16'h0, d};
        sel_i <= 4'h3;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic bc(input logic [19:0] a, input logic m, input logic [14:0] e);
        exp_q.push_back({17'h0, e});
        @(posedge clk_i);
        bus_addr_i <= a;
        bus_mem_i <= m;
        bus_addr_phase_i <= 1'b1;
        slow_r <= 2'($urandom);
        @(posedge clk_i);
        bus_addr_phase_i <= 1'b0;
        do @(posedge clk_i); while (bus_ready_o !== 1'b1);
        bus_cycle_end_i <= 1'b1;
        @(posedge clk_i);
        bus_cycle_end_i <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hca16));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        bc(20'h00002, 1'b1, {8'hff, 2'b11, 4'h0, 1'b0});
        wb(8'ha4, 1'b0, 16'h0000);
        wb(8'hfc, 1'b1, 16'hffff);
        wb(8'hfc, 1'b0, 16'h0000);
        wb(8'ha8, 1'b0, 16'h0000);
        bc(20'h00002, 1'b1, {8'hff, 2'b01, 4'h0, 1'b0});
        wb(8'ha8, 1'b1, 16'h80c0);
        pb = 9'($urandom);
        for (int i = 0; i < 8; i++) begin
            wb(8'ha4, 1'b1, {pb, 3'b111, i[2], i[0], i[1:0]});
            bc({pb, 11'h0} + 20'(i % 4) * 20'h100 + 20'($urandom % 256), 1'b1,
                {4'hf, ~(4'h1 << (i % 4)), 2'b11, wtab[i], i[0]});
        end
        for (int j = 0; j < 4; j++) begin
            wb(8'ha8, 1'b1, {8'h80, 6'b111110, j[1:0]});
            bc({pb, 11'h0} + 20'h500 + 20'(j % 2) * 20'h100 + 20'($urandom % 256), 1'b1,
                {8'hff, (j % 2 == 1) ? 2'b01 : 2'b10, 4'(j), 1'b0});
        end
        bc({pb, 11'h0} + 20'h400, 1'b1, {8'hff, 2'b11, 4'h0, 1'b0});
        bc({pb, 11'h0}, 1'b0, {8'hff, 2'b11, 4'h0, 1'b0});
        pb[8:5] = 4'h0;
        wb(8'ha4, 1'b1, {pb, 3'b111, 1'b0, 1'b1, 2'b01});
        wb(8'ha8, 1'b1, {8'h80, 8'hb8});
        bc({pb, 11'h100}, 1'b0, {4'hf, 4'hd, 2'b11, 4'h1, 1'b1});
        bc({pb, 11'h100}, 1'b1, {8'hff, 2'b11, 4'h0, 1'b0});
        for (int k = 0; k < 7; k++) begin
            blk = 20'h02000 << k;
            mb = (k == 6) ? 20'h0 : blk;
            wb(8'hac, 1'b1, {mb[19:13], 6'h3f, 1'b1, 2'(k % 4)});
            wb(8'ha8, 1'b1, {1'b1, 7'(1 << k), 8'hb8});
            bc(mb + 20'(k % 4) * (blk >> 2) + 20'($urandom) % (blk >> 2), 1'b1,
                {~(4'h1 << (k % 4)), 4'hf, 2'b11, 4'(k % 4), 1'b1});
        end
        wb(8'hb0, 1'b1, 16'h0001);
        bc(20'h40000 + 20'($urandom % 131072), 1'b1, {8'haf, 2'b11, 4'h2, 1'b1});
        bc(20'h80010, 1'b1, {8'hff, 2'b11, 4'h0, 1'b0});
        wb(8'ha8, 1'b1, {8'hc0, 8'h38});
        for (int a = 1; a < 3; a++) begin
            bc(20'h40000 + 20'(a * 2), 1'b1, {8'haf, 2'(a), 4'h2, 1'b1});
        end
        conclude();
    end
endmodule
